/* common/twm_pkg.sv */
// package for the two-wire master front end: timing and command codes
// assumes a 25 MHz system clock driving the master logic
package twm_pkg;
   // system clock period in ns
   localparam int CLK_NS = 40;
   // power-up wait before first command, in us
   localparam int POWER_UP_WAIT_TIME_US = 100;
   localparam int PUP_CYC = (POWER_UP_WAIT_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
   // half period of the generated serial clock, in ns (100 kHz bus)
   localparam int HALF_NS = 5000;
   localparam int HALF_CYC = HALF_NS / CLK_NS;
   // last data bit index, and the acknowledge slot index
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // last dummy clock index for bus recovery (ten clocks at most)
   localparam logic [3:0] RECOV_MAX = 4'h9;
   localparam int FIFO_DEPTH = 16;
   localparam int DATA_W = 8;
   // command codes carried beside each byte
   typedef enum logic [2:0] {
      TWM_CMD_WRITE   = 3'h0,
      TWM_CMD_READ    = 3'h1,
      TWM_CMD_START   = 3'h2,
      TWM_CMD_STOP    = 3'h3,
      TWM_CMD_RECOVER = 3'h4
   } twm_cmd_t;
endpackage

/* src/twm_master.sv */
// two-wire bus master: start, stop, byte write/read with ack, recovery
// assumes an open-drain bus with pull-ups resolved by the surroundings
// Contract
// R1 - device ignores bus during its power-on reset
// R2 - master waits power-up time before commands
// R3 - data sampled on clock rise, changed on fall
// R4 - bytes shifted most significant bit first
// R5 - nine clocks per byte, ninth is ack
// R6 - no pauses or extra clocks within byte
// R7 - data changes only while clock low
// R8 - falling data, clock high, means start
// R9 - rising data, clock high, means stop
// R10 - device silent until a start is seen
// R11 - repeated start may replace a stop
// R12 - byte count between start, stop unrestricted
// R13 - bus idle only when both lines high
// R14 - sender releases after eighth, receiver acks ninth
// R15 - master nack ends read, device releases line
// R16 - receiver releases line after ack clock
// R17 - device only pulls data line low
// R18 - device standby after power-up, stop, write
// R19 - recovery clocks until data high, then start
// R20 - device ignores bus during internal write
// R21 - device deglitches both lines
`timescale 1ns/1ns
`default_nettype none

// command fifo between user and bus engine
module twm_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wp_r;
   logic [AW:0]  rp_r;
   logic         full;
   logic         empty;

   // extra pointer bit tells full from empty
   assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty     = (wp_r == rp_r);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rp_r[AW-1:0]];

   // storage written without reset
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (in_valid && !full) begin
            wp_r <= wp_r + 1'b1;
         end
         if (out_ready && !empty) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule

// bus engine; the engine makes the serial clock by dividing clk
module twm_master (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // command input: cmd code plus write byte
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic [2:0] cmd_code,
   input  wire logic [7:0] cmd_data,
   input  wire logic       cmd_nack,
   // result output
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   output logic            rsp_ack,
   output logic            ready_out,
   // bus pins, open drain
   output logic            scl_o,
   output logic            scl_oe,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe
);
   typedef enum logic [2:0] {
      TWM_S_PUP   = 3'b000,
      TWM_S_IDLE  = 3'b001,
      TWM_S_START = 3'b010,
      TWM_S_BIT   = 3'b011,
      TWM_S_STOP  = 3'b100,
      TWM_S_RECOV = 3'b101
   } twm_state_t;

   twm_state_t   st_r;
   logic [14:0]  tmr_r;
   logic [1:0]   ph_r;
   logic [3:0]   bit_r;
   logic [7:0]   sh_r;
   logic         rd_r;
   logic         nack_r;
   logic         scl_low_r;
   logic         sda_low_r;
   logic [2:0]   sda_sync_r;
   logic         sda_s;
   logic         tick;
   logic         f_valid;
   logic         f_take;
   logic [11:0]  f_data;
   logic         rsp_valid_r;
   logic [7:0]   rsp_data_r;
   logic         rsp_ack_r;
   logic         open_r;

   // command queue; drain stalls while a byte is on the bus
   twm_fifo #(.W(12), .D(twm_pkg::FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .in_data   ({cmd_nack, cmd_code, cmd_data}),
      .out_valid (f_valid),
      .out_ready (f_take),
      .out_data  (f_data)
   );

   // data line input: three stages, change counted when last two agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_sync_r <= 3'h7;
         sda_s      <= 1'b1;
      end else begin
         sda_sync_r <= {sda_sync_r[1:0], sda_i};
         if (sda_sync_r[2] == sda_sync_r[1]) begin
            sda_s <= sda_sync_r[2];
         end
      end
   end

   // quarter-bit phase timer
   assign tick   = (tmr_r == 15'h0000);
   assign f_take = f_valid && (st_r == TWM_S_IDLE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_r <= 15'(twm_pkg::PUP_CYC);
      end else if (tick || f_take) begin
         tmr_r <= 15'(twm_pkg::HALF_CYC / 2 - 1);
      end else begin
         tmr_r <= tmr_r - 15'h0001;
      end
   end

   // bus sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r        <= TWM_S_PUP;
         ph_r        <= 2'h0;
         bit_r       <= 4'h0;
         sh_r        <= 8'h00;
         rd_r        <= 1'b0;
         nack_r      <= 1'b0;
         scl_low_r   <= 1'b0;
         sda_low_r   <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= 8'h00;
         rsp_ack_r   <= 1'b0;
         open_r      <= 1'b0;
      end else begin
         rsp_valid_r <= 1'b0;
         case (st_r)
            // R2 power-up wait
            TWM_S_PUP: begin
               if (tick) begin
                  st_r <= TWM_S_IDLE;
               end
            end
            TWM_S_IDLE: begin
               ph_r  <= 2'h0;
               bit_r <= 4'h0;
               // R16 data let go a cycle after clock falls, never together
               sda_low_r <= 1'b0;
               // R12 any number of bytes between start and stop
               if (f_take) begin
                  sh_r   <= f_data[7:0];
                  nack_r <= f_data[11];
                  rd_r   <= (f_data[10:8] == 3'(twm_pkg::TWM_CMD_READ));
                  case (f_data[10:8])
                     3'(twm_pkg::TWM_CMD_START):   st_r <= TWM_S_START;
                     3'(twm_pkg::TWM_CMD_STOP):    st_r <= TWM_S_STOP;
                     3'(twm_pkg::TWM_CMD_RECOVER): st_r <= TWM_S_RECOV;
                     default:                      st_r <= TWM_S_BIT;
                  endcase
               end
            end
            // R8 R11 start or repeated start: release data, clock high, pull data
            TWM_S_START: begin
               if (tick) begin
                  ph_r <= ph_r + 2'h1;
                  case (ph_r)
                     2'h0: sda_low_r <= 1'b0;
                     2'h1: scl_low_r <= 1'b0;
                     2'h2: sda_low_r <= 1'b1;
                     default: begin
                        scl_low_r <= 1'b1;
                        open_r    <= 1'b1;
                        st_r      <= TWM_S_IDLE;
                     end
                  endcase
               end
            end
            // R4 R5 R6 nine clocks, msb first, no pauses
            TWM_S_BIT: begin
               if (tick) begin
                  ph_r <= ph_r + 2'h1;
                  case (ph_r)
                     // R7 R14 data set while clock low
                     2'h0: begin
                        if (bit_r == twm_pkg::ACK_SLOT) begin
                           sda_low_r <= rd_r && !nack_r;
                        end else begin
                           sda_low_r <= !rd_r && !sh_r[7];
                        end
                     end
                     2'h1: scl_low_r <= 1'b0;
                     // R3 sample mid high phase
                     2'h2: begin
                        if (bit_r == twm_pkg::ACK_SLOT) begin
                           rsp_ack_r <= !sda_s;
                        end else begin
                           sh_r <= {sh_r[6:0], sda_s};
                        end
                     end
                     default: begin
                        scl_low_r <= 1'b1;
                        // R5 answer after ack clock; idle then frees data
                        if (bit_r == twm_pkg::ACK_SLOT) begin
                           rsp_valid_r <= 1'b1;
                           rsp_data_r  <= sh_r;
                           st_r        <= TWM_S_IDLE;
                        end
                        bit_r <= bit_r + 4'h1;
                     end
                  endcase
               end
            end
            // R9 R15 stop: data low, clock high, release data
            TWM_S_STOP: begin
               if (tick) begin
                  ph_r <= ph_r + 2'h1;
                  case (ph_r)
                     // R13 bus already idle: pulling data would be a start
                     2'h0: begin
                        if (open_r) begin
                           sda_low_r <= 1'b1;
                        end else begin
                           st_r <= TWM_S_IDLE;
                        end
                     end
                     2'h1: scl_low_r <= 1'b0;
                     2'h2: sda_low_r <= 1'b0;
                     default: begin
                        open_r <= 1'b0;
                        st_r   <= TWM_S_IDLE;
                     end
                  endcase
               end
            end
            // R19 dummy clocks until data high, at most ten
            TWM_S_RECOV: begin
               if (tick) begin
                  ph_r      <= ph_r + 2'h1;
                  sda_low_r <= 1'b0;
                  case (ph_r)
                     2'h0: scl_low_r <= 1'b1;
                     2'h1: scl_low_r <= 1'b0;
                     2'h2: begin
                        if (sda_s || bit_r == twm_pkg::RECOV_MAX) begin
                           rsp_ack_r   <= sda_s;
                           rsp_valid_r <= 1'b1;
                           rsp_data_r  <= 8'h00;
                           open_r      <= 1'b0;
                           st_r        <= TWM_S_IDLE;
                        end
                     end
                     default: bit_r <= bit_r + 4'h1;
                  endcase
               end
            end
            default: st_r <= TWM_S_IDLE;
         endcase
      end
   end

   // outputs registered; pins only ever pull low (open drain)
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_oe    <= 1'b0;
         sda_oe    <= 1'b0;
         ready_out <= 1'b0;
      end else begin
         scl_oe    <= scl_low_r;
         sda_oe    <= sda_low_r;
         ready_out <= (st_r != TWM_S_PUP);
      end
   end

   assign scl_o     = 1'b0;
   assign sda_o     = 1'b0;
   assign rsp_valid = rsp_valid_r;
   assign rsp_data  = rsp_data_r;
   assign rsp_ack   = rsp_ack_r;
endmodule
`default_nettype wire

/* verification/twm_dev_model.sv */
// memory-side bus model: start/stop, byte in, ack, byte out
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/1ns
`default_nettype none
module twm_dev_model (
   // power and bus
   input wire logic       por_n,
   input wire logic       scl,
   input wire logic       sda,
   // read mode and byte to send
   input wire logic       rd,
   input wire logic [7:0] tx,
   output logic           sda_pull
);
   logic       act = 1'b0;
   logic       drv = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00;
   int         stk = 0;
   // stk holds the line low for that many falls, a stuck slave
   assign sda_pull = drv || stk > 0;
   always @(negedge sda) if (scl && por_n) begin
      act = 1'b1;
      cnt = 4'h0;
   end
   always @(posedge sda) if (scl) begin
      act = 1'b0;
      drv = 1'b0;
   end
   always @(posedge scl) if (act) begin
      if (cnt < 4'h8) sh = {sh[6:0], sda};
      else if (rd && sda) act = 1'b0;
      cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
   end
   always @(negedge scl) begin
      if (stk > 0) stk--;
      if (!act || !por_n) drv = 1'b0;
      else if (rd) drv = cnt < 4'h8 && !tx[3'h7 - cnt[2:0]];
      else drv = cnt == 4'h8;
   end
endmodule
`default_nettype wire

/* verification/twm_master_bench.sv */
// bench: two-wire master against the memory-side model
// assumes package, fifo, master, model and checker compiled before
`timescale 1ns/1ns
`default_nettype none
module twm_master_bench;
   logic       clk;
   logic       rst_n;
   logic       cmd_valid;
   logic [2:0] cmd_code;
   logic [7:0] cmd_data;
   logic       cmd_nack;
   logic       cmd_ready;
   logic       rsp_valid;
   logic [7:0] rsp_data;
   logic       rsp_ack;
   logic       ready_out;
   logic       scl_oe;
   logic       sda_oe;
   logic       dev_pull;
   logic       rd;
   int         fail_count;
   int         samples_checked;
   // open-drain lines with pull-ups
   wire        scl = !scl_oe;
   wire        sda = !(sda_oe | dev_pull);
   twm_master twm_master_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .ready_out(ready_out),
      .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
   twm_dev_model twm_dev_model_i (.por_n(rst_n), .scl(scl), .sda(sda), .rd(rd),
      .tx(8'h96), .sda_pull(dev_pull));
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   // offer one command, held until the fifo takes it
   task automatic send(input logic [2:0] c, input logic [7:0] d, input logic k);
      int i;
      @(posedge clk);
      #1 cmd_code = c;
      cmd_data = d;
      cmd_nack = k;
      cmd_valid = 1'b1;
      i = 0;
      // ready looked at once settled, so the coming edge takes the command
      while (cmd_ready !== 1'b1 && i < 5000) begin
         @(posedge clk);
         #1 i++;
      end
      @(posedge clk);
      #1 cmd_valid = 1'b0;
   endtask
   // bounded wait for the one-cycle result pulse
   task automatic wait_rsp();
      int i;
      i = 0;
      do begin
         @(posedge clk);
         #1 i++;
      end while (rsp_valid !== 1'b1 && i < 8000);
      chk("rsp_valid", {7'h00, rsp_valid}, 8'h01);
   endtask
   // queue starts before power-up until the fifo refuses
   task automatic t_fill();
      int n;
      n = 0;
      cmd_code = twm_pkg::TWM_CMD_START;
      cmd_valid = 1'b1;
      // ready sampled settled, before the edge that takes the entry
      repeat (20) begin
         if (cmd_ready === 1'b1) n++;
         @(posedge clk);
         #1;
      end
      cmd_valid = 1'b0;
      chk("queued", n[7:0], 8'h10);
      chk("scl_oe", {7'h00, scl_oe}, 8'h00);
      while (ready_out !== 1'b1 && n < 3100) begin
         @(posedge clk);
         #1 n++;
      end
      chk("ready_out", {7'h00, ready_out}, 8'h01);
   endtask
   // two writes back to back after the queued starts
   task automatic t_write();
      send(twm_pkg::TWM_CMD_WRITE, 8'hA5, 1'b0);
      send(twm_pkg::TWM_CMD_WRITE, 8'h01, 1'b0);
      wait_rsp();
      chk("ack", {7'h00, rsp_ack}, 8'h01);
      chk("dev_rx", twm_dev_model_i.sh, 8'hA5);
      chk("echo", rsp_data, 8'hA5);
      wait_rsp();
      chk("ack", {7'h00, rsp_ack}, 8'h01);
      chk("dev_rx", twm_dev_model_i.sh, 8'h01);
   endtask
   // repeated start, read with ack, read with nack, stop
   task automatic t_read();
      rd = 1'b1;
      send(twm_pkg::TWM_CMD_START, 8'h00, 1'b0);
      send(twm_pkg::TWM_CMD_READ, 8'h00, 1'b0);
      send(twm_pkg::TWM_CMD_READ, 8'h00, 1'b1);
      send(twm_pkg::TWM_CMD_STOP, 8'h00, 1'b0);
      wait_rsp();
      chk("rd_data", rsp_data, 8'h96);
      chk("ack", {7'h00, rsp_ack}, 8'h01);
      wait_rsp();
      chk("rd_data", rsp_data, 8'h96);
      chk("ack", {7'h00, rsp_ack}, 8'h00);
      chk("sda", {7'h00, sda}, 8'h01);
   endtask
   // stuck data line cleared, then a fresh start and write
   task automatic t_recover();
      rd = 1'b0;
      twm_dev_model_i.stk = 3;
      send(twm_pkg::TWM_CMD_RECOVER, 8'h00, 1'b0);
      wait_rsp();
      chk("freed", {7'h00, rsp_ack}, 8'h01);
      send(twm_pkg::TWM_CMD_START, 8'h00, 1'b0);
      send(twm_pkg::TWM_CMD_WRITE, 8'h5A, 1'b0);
      wait_rsp();
      chk("ack", {7'h00, rsp_ack}, 8'h01);
      chk("dev_rx", twm_dev_model_i.sh, 8'h5A);
   endtask
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_code = 3'h0;
      cmd_data = 8'h00;
      cmd_nack = 1'b0;
      rd = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      t_fill();
      t_write();
      t_read();
      t_recover();
      wrap_up();
   end
   // watchdog well past the expected run length
   initial begin
      #2400000;
      fail_count++;
      wrap_up();
   end
endmodule
`default_nettype wire

/* verification/twm_master_monitor.sv */
// checker: bus timing seen at the master's ports
// assumes twm_pkg is compiled first; bound onto twm_master below
`timescale 1ns/1ns
`default_nettype none
module twm_master_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // status
   input wire logic rsp_valid,
   input wire logic rsp_ack,
   input wire logic ready_out,
   // bus pins
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // cycles since reset, saturates so it never wraps
   int up_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) up_r <= 0;
      else if (up_r < 9999) up_r <= up_r + 1;
   end
   pins_low_a: assert property (!scl_o && !sda_o)
      else $error("bus pin driven high");
   bus_quiet_a: assert property (!ready_out |-> !scl_oe && !sda_oe)
      else $error("bus moved before wait");
   wait_done_a: assert property ($rose(ready_out) |-> up_r inside {[2500:2504]})
      else $error("power-up wait wrong");
   one_line_a: assert property ($changed(scl_oe) |-> $stable(sda_oe))
      else $error("both lines moved");
   rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
      else $error("rsp_valid too long");
   high_span_a: assert property ($fell(scl_oe) |-> (!scl_oe) [*8])
      else $error("clock high too short");
   start_hold_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:70] scl_oe)
      else $error("start not followed by low clock");
   stop_idle_a: assert property ($fell(sda_oe) && !scl_oe |-> (!scl_oe && !sda_oe) [*8])
      else $error("stop not left idle");
   acked_c: cover property (rsp_valid && rsp_ack);
   nacked_c: cover property (rsp_valid && !rsp_ack);
   ready_c: cover property ($rose(ready_out));
endmodule
bind twm_master twm_master_monitor twm_master_monitor_i (.clk(clk), .rst_n(rst_n),
   .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .ready_out(ready_out), .scl_o(scl_o),
   .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire
